/* File: ddrs_defines.svh */
// constants for the ddr output and strobe alignment block
`ifndef DDRS_DEFINES_SVH
`define DDRS_DEFINES_SVH
`define DDRS_CAL_W 6
`define DDRS_TAPS 64
`define DDRS_CAL_RESET 6'h20
`define DDRS_CAL_STEP 6'h01
`define DDRS_GROUPS 2
`define DDRS_PADS_FULL 14
`define DDRS_PADS_SHORT 12
`define DDRS_DATA_PER_GROUP 8
`define DDRS_MAX_WIDTH 16
`define DDRS_REF_LAT 3
`define DDRS_LOCK_W 5
`define DDRS_LOCK_COUNT 5'h10
`endif

/* File: ddrs_pkg.sv */
// types of the ddr output and strobe alignment block
package ddrs_pkg;
  typedef enum logic [1:0] {ddrs_sdr, ddrs_generic, ddrs_memory} ddrs_mode_type;
  typedef enum logic [1:0] {ddrs_idle, ddrs_wait_low, ddrs_preamble, ddrs_active} ddrs_state_type;
endpackage

/* File: ddrs_strobe_if.sv */
// strobe-derived clocks and controls shared inside one pad group
`include "ddrs_defines.svh"
interface ddrs_strobe_if;
  logic read_strobe_shifted;
  logic write_strobe_shifted;
  logic capture_polarity_select;
  logic read_rise;
  logic read_fall;
  logic [`DDRS_CAL_W-1:0] cal_code;
  modport src (
    output read_strobe_shifted, write_strobe_shifted, capture_polarity_select,
    output read_rise, read_fall,
    input cal_code
  );
  modport sink (
    input read_strobe_shifted, write_strobe_shifted, capture_polarity_select,
    input read_rise, read_fall, cal_code
  );
endinterface

/* File: ddrs_out_cell.sv */
// one pad output register block: sdr, generic ddr, memory ddr
`include "ddrs_defines.svh"
module ddrs_out_cell #(
  parameter bit RIGHT_EDGE = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration
  input wire ddrs_pkg::ddrs_mode_type mode,
  input wire logic latch_sel,
  // core data
  input wire logic out_bit_first,
  input wire logic out_bit_second,
  input wire logic out_enable,
  // strobes of the group
  ddrs_strobe_if.sink strobe,
  // pad
  output logic pad_out,
  output logic pad_oe
);
  import ddrs_pkg::*;
  logic hold_reg_first, cap_second, hold_reg_second, sdr_ff, sdr_latch, mem_q;
  logic next_mem_q;
  ddrs_mode_type eff_mode;
  // left, top and bottom cells have no memory mode
  assign eff_mode = (!RIGHT_EDGE && mode == ddrs_memory) ? ddrs_generic : mode;
  always_comb begin
    next_mem_q = strobe.write_strobe_shifted ? hold_reg_second : hold_reg_first;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg_first <= 1'b0;
      cap_second <= 1'b0;
      sdr_ff <= 1'b0;
      mem_q <= 1'b0;
      pad_oe <= 1'b0;
    end else begin
      hold_reg_first <= out_bit_first;
      cap_second <= out_bit_second;
      sdr_ff <= out_bit_first;
      mem_q <= next_mem_q;
      pad_oe <= out_enable;
    end
  end
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg_second <= 1'b0;
    end else begin
      hold_reg_second <= cap_second;
    end
  end
  always_latch begin
    if (!rst_n) begin
      sdr_latch <= 1'b0;
    end else if (core_clk) begin
      sdr_latch <= out_bit_first;
    end
  end
  always_comb begin
    case (eff_mode)
      ddrs_sdr: pad_out = latch_sel ? sdr_latch : sdr_ff;
      ddrs_generic: pad_out = core_clk ? hold_reg_first : hold_reg_second;
      ddrs_memory: pad_out = mem_q;
      default: pad_out = sdr_ff;
    endcase
  end
endmodule // ddrs_out_cell

/* File: ddrs_strobe_ctl.sv */
// strobe read/write block: shifted strobes and capture polarity
`include "ddrs_defines.svh"
module ddrs_strobe_ctl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // strobe pad and read request
  input wire logic dqs_pad_in,
  input wire logic read_en,
  // group strobe bus
  ddrs_strobe_if.src strobe
);
  import ddrs_pkg::*;
  logic pos_meta, pos_sync, pos_prev, neg_meta, neg_sync, neg_prev;
  logic [`DDRS_TAPS-1:0] tap_line, next_tap_line;
  logic next_rss, next_wss, next_pol, next_rise, next_fall;
  ddrs_state_type state, next_state;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_meta <= 1'b0;
      pos_sync <= 1'b0;
    end else begin
      pos_meta <= dqs_pad_in;
      pos_sync <= pos_meta;
    end
  end
  // falling-edge samples tell in which clock half the strobe rose
  always_ff @(negedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_meta <= 1'b0;
      neg_sync <= 1'b0;
      neg_prev <= 1'b0;
    end else begin
      neg_meta <= dqs_pad_in;
      neg_sync <= neg_meta;
      // falling sample taken just ahead of the rising one that sees the edge
      neg_prev <= neg_sync;
    end
  end
  always_comb begin
    next_tap_line = {tap_line[`DDRS_TAPS-2:0], pos_sync};
    next_rss = tap_line[strobe.cal_code];
    next_wss = tap_line[strobe.cal_code >> 1];
    next_rise = (state == ddrs_active) && next_rss && !strobe.read_strobe_shifted;
    next_fall = (state == ddrs_active) && !next_rss && strobe.read_strobe_shifted;
    next_pol = strobe.capture_polarity_select;
    next_state = state;
    case (state)
      ddrs_idle: if (read_en) next_state = ddrs_wait_low;
      ddrs_wait_low: if (!pos_sync) next_state = ddrs_preamble;
      ddrs_preamble: begin
        if (pos_sync && !pos_prev && read_en) begin
          next_state = ddrs_active;
          next_pol = neg_prev;
        end
      end
      ddrs_active: next_state = ddrs_active;
      default: next_state = ddrs_idle;
    endcase
    if (!read_en) next_state = ddrs_idle;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_prev <= 1'b0;
      tap_line <= '0;
      state <= ddrs_idle;
      strobe.read_strobe_shifted <= 1'b0;
      strobe.write_strobe_shifted <= 1'b0;
      strobe.capture_polarity_select <= 1'b0;
      strobe.read_rise <= 1'b0;
      strobe.read_fall <= 1'b0;
    end else begin
      pos_prev <= pos_sync;
      tap_line <= next_tap_line;
      state <= next_state;
      strobe.read_strobe_shifted <= next_rss;
      strobe.write_strobe_shifted <= next_wss;
      strobe.capture_polarity_select <= next_pol;
      strobe.read_rise <= next_rise;
      strobe.read_fall <= next_fall;
    end
  end
endmodule // ddrs_strobe_ctl

/* File: ddrs_top.sv */
// right-edge ddr output registers, strobe alignment, read capture and dll
//
// Contract
// - sdr mode sends first core bit through one register or latch.
// - generic ddr captures both bits on rise, second bit again on fall.
// - generic ddr output mux alternates holding registers on system clock.
// - right-edge cells add memory ddr mode to sdr and generic modes.
// - memory ddr captures bits like generic mode, second on falling edge.
// - memory ddr output mux is switched by the shifted write strobe.
// - two groups of fourteen or twelve pads, sixteen data bits at most.
// - one strobe block per group makes strobes, polarity and read rise/fall pulses.
// - strobe clocks and controls reach every pad of its group.
// - shifted read and write strobes both come from the dqs input.
// - polarity picks the edge moving read data into system clock domain.
// - capture polarity is evaluated again at the start of every read.
// - first dqs rising edge after preamble sets the capture polarity.
// - capture polarity selects the rising- or falling-edge synchronizing register copy.
// - strobe delay takes a six-bit calibration code from the dll.
// - dll keeps its code compensated from system clock and feedback.
`include "ddrs_defines.svh"
module ddrs_top #(
  parameter int GROUP_PADS = `DDRS_PADS_FULL,
  parameter int NUM_GROUPS = `DDRS_GROUPS,
  parameter int DATA_PER_GROUP = `DDRS_DATA_PER_GROUP,
  parameter int PAD_W = GROUP_PADS * NUM_GROUPS,
  parameter int DATA_W = DATA_PER_GROUP * NUM_GROUPS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // configuration
  input wire ddrs_pkg::ddrs_mode_type mode_sel,
  input wire logic latch_sel,
  // core write data
  input wire logic [PAD_W-1:0] out_bit_first,
  input wire logic [PAD_W-1:0] out_bit_second,
  input wire logic [PAD_W-1:0] out_enable,
  // pads
  output logic [PAD_W-1:0] pad_out,
  output logic [PAD_W-1:0] pad_oe,
  input wire logic [PAD_W-1:0] pad_in,
  // strobes and read requests
  input wire logic [NUM_GROUPS-1:0] dqs_pad_in,
  input wire logic [NUM_GROUPS-1:0] read_en,
  // dll loop
  input wire logic dll_fb_in,
  output logic dll_ref_out,
  output logic [`DDRS_CAL_W-1:0] cal_code,
  output logic dll_locked,
  // group strobe status
  output logic [NUM_GROUPS-1:0] read_strobe_shifted,
  output logic [NUM_GROUPS-1:0] write_strobe_shifted,
  output logic [NUM_GROUPS-1:0] capture_polarity_select,
  // captured read data
  output logic [DATA_W-1:0] read_word_first,
  output logic [DATA_W-1:0] read_word_second,
  output logic [NUM_GROUPS-1:0] capture_word_valid
);
  import ddrs_pkg::*;

  // elaboration checks
  if (GROUP_PADS != `DDRS_PADS_FULL && GROUP_PADS != `DDRS_PADS_SHORT) begin : g_bad_pads
    $error("group pad count must be fourteen or twelve");
  end
  if (DATA_W > `DDRS_MAX_WIDTH) begin : g_bad_width
    $error("memory data width too large");
  end
  if (DATA_PER_GROUP > GROUP_PADS - 1) begin : g_bad_data
    $error("data pads must leave room for the strobe pad");
  end

  // reset release
  logic rst_meta_n, rst_sync_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // configuration register
  ddrs_mode_type mode, next_mode;
  logic latch_mode, next_latch_mode;
  always_comb begin
    next_mode = mode_sel;
    next_latch_mode = latch_sel;
  end
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode <= ddrs_sdr;
      latch_mode <= 1'b0;
    end else begin
      mode <= next_mode;
      latch_mode <= next_latch_mode;
    end
  end

  // dll: reference toggle, feedback compare, code search
  logic fb_meta, fb_sync;
  logic [`DDRS_REF_LAT-1:0] ref_hist, next_ref_hist;
  logic next_ref;
  logic [`DDRS_CAL_W-1:0] next_cal_code;
  logic [`DDRS_LOCK_W-1:0] match_cnt, next_match_cnt;
  logic next_locked;
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fb_meta <= 1'b0;
      fb_sync <= 1'b0;
    end else begin
      fb_meta <= dll_fb_in;
      fb_sync <= fb_meta;
    end
  end
  always_comb begin
    next_ref = !dll_ref_out;
    next_ref_hist = {ref_hist[`DDRS_REF_LAT-2:0], dll_ref_out};
    next_cal_code = cal_code;
    next_match_cnt = match_cnt;
    if (fb_sync == ref_hist[`DDRS_REF_LAT-1]) begin
      if (match_cnt != `DDRS_LOCK_COUNT) begin
        next_match_cnt = match_cnt + `DDRS_LOCK_W'(1);
      end
    end else begin
      next_match_cnt = '0;
      next_cal_code = cal_code + `DDRS_CAL_STEP;
    end
    next_locked = (next_match_cnt == `DDRS_LOCK_COUNT);
  end
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dll_ref_out <= 1'b0;
      ref_hist <= '0;
      cal_code <= `DDRS_CAL_RESET;
      match_cnt <= '0;
      dll_locked <= 1'b0;
    end else begin
      dll_ref_out <= next_ref;
      ref_hist <= next_ref_hist;
      cal_code <= next_cal_code;
      match_cnt <= next_match_cnt;
      dll_locked <= next_locked;
    end
  end

  // pad groups
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    ddrs_strobe_if strobe_bus ();
    assign strobe_bus.cal_code = cal_code;

    // strobe control element on the group's strobe pad
    ddrs_strobe_ctl u_strobe (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .dqs_pad_in(dqs_pad_in[g]),
      .read_en(read_en[g]),
      .strobe(strobe_bus.src)
    );

    assign read_strobe_shifted[g] = strobe_bus.read_strobe_shifted;
    assign write_strobe_shifted[g] = strobe_bus.write_strobe_shifted;
    assign capture_polarity_select[g] = strobe_bus.capture_polarity_select;

    // output cells, all fed by the group's strobe bus
    for (genvar p = 0; p < GROUP_PADS; p++) begin : g_pad
      ddrs_out_cell #(
        .RIGHT_EDGE(1'b1)
      ) u_cell (
        .core_clk(core_clk),
        .rst_n(rst_sync_n),
        .mode(mode),
        .latch_sel(latch_mode),
        .out_bit_first(out_bit_first[g*GROUP_PADS+p]),
        .out_bit_second(out_bit_second[g*GROUP_PADS+p]),
        .out_enable(out_enable[g*GROUP_PADS+p]),
        .strobe(strobe_bus.sink),
        .pad_out(pad_out[g*GROUP_PADS+p]),
        .pad_oe(pad_oe[g*GROUP_PADS+p])
      );
    end

    // input synchronizing registers on both clock edges
    logic [DATA_PER_GROUP-1:0] rise_meta, rise_sync, fall_meta, fall_sync;
    logic [DATA_PER_GROUP-1:0] sel_data;
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        rise_meta <= '0;
        rise_sync <= '0;
      end else begin
        rise_meta <= pad_in[g*GROUP_PADS +: DATA_PER_GROUP];
        rise_sync <= rise_meta;
      end
    end
    always_ff @(negedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        fall_meta <= '0;
        fall_sync <= '0;
      end else begin
        fall_meta <= pad_in[g*GROUP_PADS +: DATA_PER_GROUP];
        fall_sync <= fall_meta;
      end
    end
    // polarity picks which edge's copy moves into the system domain
    always_comb begin
      sel_data = strobe_bus.capture_polarity_select ? fall_sync : rise_sync;
    end

    // word assembly: rise gives first bit, fall gives second and completes
    logic [DATA_PER_GROUP-1:0] word_first, next_word_first;
    logic [DATA_PER_GROUP-1:0] word_second, next_word_second;
    logic [DATA_PER_GROUP-1:0] pend_first, next_pend_first;
    logic pend_valid, next_pend_valid;
    logic word_valid, next_word_valid;
    always_comb begin
      next_pend_first = pend_first;
      next_pend_valid = pend_valid;
      next_word_first = word_first;
      next_word_second = word_second;
      next_word_valid = 1'b0;
      if (!read_en[g]) begin
        next_pend_valid = 1'b0;
      end else if (strobe_bus.read_rise) begin
        next_pend_first = sel_data;
        next_pend_valid = 1'b1;
      end else if (strobe_bus.read_fall && pend_valid) begin
        next_word_first = pend_first;
        next_word_second = sel_data;
        next_word_valid = 1'b1;
        next_pend_valid = 1'b0;
      end
    end
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        pend_first <= '0;
        pend_valid <= 1'b0;
        word_first <= '0;
        word_second <= '0;
        word_valid <= 1'b0;
      end else begin
        pend_first <= next_pend_first;
        pend_valid <= next_pend_valid;
        word_first <= next_word_first;
        word_second <= next_word_second;
        word_valid <= next_word_valid;
      end
    end
    assign read_word_first[g*DATA_PER_GROUP +: DATA_PER_GROUP] = word_first;
    assign read_word_second[g*DATA_PER_GROUP +: DATA_PER_GROUP] = word_second;
    assign capture_word_valid[g] = word_valid;
  end
endmodule // ddrs_top

/* File: ddrs_top_props.sv */
// checker bound to the ddr output and strobe top
`include "ddrs_defines.svh"
module ddrs_top_props #(parameter int PAD_W = 28, parameter int NUM_GROUPS = 2) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ddrs_pkg::ddrs_mode_type mode_sel,
  input wire logic latch_sel,
  input wire logic [PAD_W-1:0] out_bit_first,
  input wire logic [PAD_W-1:0] out_bit_second,
  input wire logic [PAD_W-1:0] pad_out,
  input wire logic [NUM_GROUPS-1:0] read_en,
  input wire logic dll_ref_out,
  input wire logic [`DDRS_CAL_W-1:0] cal_code,
  input wire logic dll_locked,
  input wire logic [NUM_GROUPS-1:0] write_strobe_shifted,
  input wire logic [NUM_GROUPS-1:0] capture_polarity_select,
  input wire logic [NUM_GROUPS-1:0] capture_word_valid
);
  import ddrs_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_sdr_flop: assert property ($past(rst_n, 4) && $past(mode_sel, 2) == ddrs_sdr &&
    $past(mode_sel) == ddrs_sdr && !$past(latch_sel) && !latch_sel
    |-> pad_out == $past(out_bit_first)) else $error("sdr pad is not the first bit");
  chk_gen_high: assert property (@(negedge core_clk) $past(mode_sel) == ddrs_generic &&
    $past(mode_sel, 2) == ddrs_generic |-> pad_out == $past(out_bit_first))
    else $error("generic high half is not the first bit");
  chk_gen_low: assert property ($past(mode_sel) == ddrs_generic &&
    $past(mode_sel, 2) == ddrs_generic |-> pad_out == $past(out_bit_second))
    else $error("generic low half is not the second bit");
  chk_mem_strobe: assert property ($past(rst_n, 4) && $past(mode_sel, 2) == ddrs_memory &&
    $past(mode_sel) == ddrs_memory && $stable(write_strobe_shifted[0]) &&
    $past(write_strobe_shifted[0]) == $past(write_strobe_shifted[0], 2)
    |-> pad_out[13:0] == ($past(write_strobe_shifted[0]) ?
    $past(out_bit_second[13:0], 2) : $past(out_bit_first[13:0], 2)))
    else $error("memory mode pad does not follow write strobe");
  chk_ref_toggle: assert property ($past(rst_n, 4) |-> dll_ref_out != $past(dll_ref_out))
    else $error("dll reference stopped");
  chk_cal_step: assert property ($changed(cal_code) |-> cal_code == $past(cal_code) + 6'h01)
    else $error("calibration code jumped");
  chk_lock_hold: assert property ($past(dll_locked) && dll_locked |-> $stable(cal_code))
    else $error("code moved while locked");
  chk_valid_pulse: assert property ((capture_word_valid & $past(capture_word_valid)) == 2'b00)
    else $error("valid held longer than one cycle");
  chk_valid_idle: assert property (read_en == 2'b00 [*6] |-> capture_word_valid == 2'b00)
    else $error("valid outside a read");
  chk_pol_hold: assert property ($past(read_en) == 2'b00 && read_en == 2'b00
    |-> $stable(capture_polarity_select)) else $error("polarity moved outside a read");
  cov_generic: cover property ($past(mode_sel) == ddrs_generic && pad_out != $past(pad_out));
  cov_word: cover property (capture_word_valid[1]);
  cov_relock: cover property ($rose(dll_locked));
endmodule // ddrs_top_props
bind ddrs_top ddrs_top_props #(.PAD_W(PAD_W), .NUM_GROUPS(NUM_GROUPS)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .mode_sel(mode_sel), .latch_sel(latch_sel),
  .out_bit_first(out_bit_first), .out_bit_second(out_bit_second), .pad_out(pad_out),
  .read_en(read_en), .dll_ref_out(dll_ref_out), .cal_code(cal_code), .dll_locked(dll_locked),
  .write_strobe_shifted(write_strobe_shifted), .capture_polarity_select(capture_polarity_select),
  .capture_word_valid(capture_word_valid)
);

/* File: ddrs_mem_model.sv */
// memory side model: strobe bursts, read data and the board dll loop
module ddrs_mem_model (
  input wire logic core_clk,
  input wire logic dll_ref_out,
  input wire logic break_loop,
  input wire logic burst_go,
  input wire logic [15:0] burst_data,
  output logic [1:0] dqs,
  output logic [15:0] dq,
  output logic dll_fb_in = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // strobe phase alternates per burst so both capture polarities occur
  bit early = 1'b1;
  // board feedback one cycle late, inverted when the loop is broken
  always @(posedge core_clk) begin
    dll_fb_in <= dll_ref_out ^ break_loop;
  end
  initial begin
    dqs = 2'b11;
    dq = 16'h0000;
    forever begin
      @(posedge burst_go);
      #(early ? 27 : 37);
      early = !early;
      dqs = 2'b00;
      dq = burst_data;
      #160;
      repeat (16) begin
        dqs = 2'b11;
        #80;
        dqs = 2'b00;
        #80;
      end
      dqs = 2'b11;
      #2000;
      dq = ~dq;
    end
  end
endmodule // ddrs_mem_model

/* File: test_ddrs_top.sv */
// self-checking bench for the ddr output and strobe top
`include "ddrs_defines.svh"
module test_ddrs_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ddrs_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  ddrs_mode_type mode_sel = ddrs_sdr;
  logic latch_sel = 1'b0;
  logic break_loop = 1'b0;
  logic burst_go = 1'b0;
  logic [15:0] burst_data = 16'h0000;
  logic [1:0] read_en = 2'b00;
  logic [27:0] out_bit_first = 28'h0000000;
  logic [27:0] out_bit_second = 28'h0000000;
  logic [27:0] out_enable = 28'h0000000;
  logic [27:0] pad_out, pad_oe, pad_in;
  logic [1:0] dqs, rss, wss, cps, cwv;
  logic [15:0] dq, rwf, rws;
  logic [5:0] cal_code, code_prev;
  logic dll_fb_in, dll_ref_out, dll_locked;
  int mismatches = 0;
  int tests_run = 0;
  int cnt0, cnt1;
  assign pad_in = {6'h00, dq[15:8], 6'h00, dq[7:0]};
  initial begin
    forever begin
      #10 core_clk = ~core_clk;
    end
  end
  ddrs_top dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .mode_sel(mode_sel), .latch_sel(latch_sel),
    .out_bit_first(out_bit_first), .out_bit_second(out_bit_second), .out_enable(out_enable),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in), .dqs_pad_in(dqs), .read_en(read_en),
    .dll_fb_in(dll_fb_in), .dll_ref_out(dll_ref_out), .cal_code(cal_code),
    .dll_locked(dll_locked), .read_strobe_shifted(rss), .write_strobe_shifted(wss),
    .capture_polarity_select(cps), .read_word_first(rwf), .read_word_second(rws),
    .capture_word_valid(cwv)
  );
  ddrs_mem_model mem_u (
    .core_clk(core_clk), .dll_ref_out(dll_ref_out), .break_loop(break_loop),
    .burst_go(burst_go), .burst_data(burst_data), .dqs(dqs), .dq(dq), .dll_fb_in(dll_fb_in)
  );
  task automatic check(input logic [27:0] got, want, input string what);
    tests_run++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, want);
    end
  endtask
  task automatic drive(input ddrs_mode_type m, input logic l, input logic [27:0] a, b, int n);
    repeat (n) begin
      @(posedge core_clk);
      mode_sel <= m;
      latch_sel <= l;
      out_bit_first <= a;
      out_bit_second <= b;
      out_enable <= a ^ b;
    end
  endtask
  task automatic wait_lock();
    for (int i = 0; i < 300 && dll_locked !== 1'b1; i++) @(posedge core_clk);
    #1;
    check(28'(dll_locked), 28'h0000001, "dll lock");
  endtask
  task automatic do_read(input logic [15:0] d, input logic [1:0] pol);
    @(posedge core_clk);
    read_en <= 2'b11;
    burst_data <= d;
    repeat (3) @(posedge core_clk);
    burst_go <= 1'b1;
    cnt0 = 0;
    cnt1 = 0;
    repeat (230) begin
      @(posedge core_clk);
      #1;
      if (cwv[0] === 1'b1) cnt0++;
      if (cwv[1] === 1'b1) cnt1++;
    end
    check(28'(rwf), 28'(d), "first read word");
    check(28'(rws), 28'(d), "second read word");
    check(28'(cps), 28'(pol), "capture polarity");
    check(28'(cnt0), 28'h0000010, "group 0 words");
    check(28'(cnt1), 28'h0000010, "group 1 words");
    @(posedge core_clk);
    read_en <= 2'b00;
    burst_go <= 1'b0;
    repeat (80) @(posedge core_clk);
    #1;
    check(28'(cwv), 28'h0000000, "valid after read");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    check(pad_out, 28'h0000000, "pad in reset");
    check(pad_oe, 28'h0000000, "enable in reset");
    check(28'(cal_code), 28'(`DDRS_CAL_RESET), "code in reset");
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    $display("test reset done");
    drive(ddrs_sdr, 1'b0, 28'h5a5a5a5, 28'h0f0f0f0, 3);
    drive(ddrs_sdr, 1'b0, 28'ha5a5a5a, 28'h0f0f0f0, 1);
    #2;
    check(pad_out, 28'h5a5a5a5, "sdr flop before edge");
    @(posedge core_clk);
    #2;
    check(pad_out, 28'ha5a5a5a, "sdr flop after edge");
    check(pad_oe, 28'haaaaaaa, "pad enable");
    drive(ddrs_sdr, 1'b1, 28'h5a5a5a5, 28'h0f0f0f0, 3);
    drive(ddrs_sdr, 1'b1, 28'h3c3c3c3, 28'h0f0f0f0, 1);
    #2;
    check(pad_out, 28'h3c3c3c3, "sdr latch open");
    drive(ddrs_generic, 1'b0, 28'h1234567, 28'h7654321, 3);
    drive(ddrs_generic, 1'b0, 28'h0ff00ff, 28'hf00ff00, 1);
    @(posedge core_clk);
    #5;
    check(pad_out, 28'h0ff00ff, "generic high half");
    @(negedge core_clk);
    #5;
    check(pad_out, 28'hf00ff00, "generic low half");
    $display("test output modes done");
    wait_lock();
    code_prev = cal_code;
    @(posedge core_clk);
    break_loop <= 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    check(28'(dll_locked), 28'h0000000, "lock lost");
    check(28'(cal_code != code_prev), 28'h0000001, "code tracks");
    @(posedge core_clk);
    break_loop <= 1'b0;
    wait_lock();
    $display("test dll done");
    drive(ddrs_memory, 1'b0, 28'h1111111, 28'heeeeeee, 5);
    #2;
    check(28'(wss), 28'h0000003, "write strobe idle");
    check(28'(rss), 28'h0000003, "read strobe idle");
    check(pad_out, 28'heeeeeee, "memory mode strobe high");
    do_read(16'ha53c, 2'b11);
    do_read(16'h5ac3, 2'b00);
    $display("test read done");
    give_verdict();
  end
  initial begin
    #100000;
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule // test_ddrs_top
